// file: hardware_reset_sequencer.sv
// Reset sequencer: power-up and warm reset, startup capture, first strobe
module hardware_reset_sequencer
    import reset_seq_pkg::*;
#(
    parameter int CFG_W = 16                      // Startup port width
) (
    input  wire logic             i_clock,             // CPU clock, 25 MHz
    input  wire logic             i_resetn,            // Power-up reset, active low
    input  wire logic             i_clock_en,          // Freezes all state when low
    input  wire logic             i_reset_in_n,        // Reset pin level seen
    output logic                  o_reset_in_n_out,    // Reset pin drive value
    output logic                  o_reset_in_n_oe,     // Reset pin drive enable
    input  wire logic [CFG_W-1:0] i_startup_config_port, // Startup port lines
    output logic                  o_port_pullup_en,    // Startup port pull-ups on
    input  wire logic             i_access_busy,       // Internal access running
    input  wire logic             i_end_of_init_instr, // End-of-init executed, pulse
    output logic                  o_cancel_holds,      // Drop pending holds, pulse
    output logic                  o_internal_reset,    // Reset condition active
    output logic                  o_reset_out_n,       // Reset output, active low
    output logic                  o_emulation_cfg_bit, // Captured emulation bit
    output logic                  o_cfg_bit_a,         // Captured cfg_bit_a bit
    output logic [2:0]            o_clock_cfg,         // Captured clock config
    output logic                  o_ale,               // First address strobe
    output logic                  o_fetch_start,       // Begin fetch, pulse
    output logic [ADDR_W-1:0]     o_fetch_addr,        // Fetch start address
    output logic                  o_io_disable         // Keep general I/O inactive
);

    // Width check at elaboration
    if (CFG_W != 16) begin : g_cfg_w_check
        $error("hardware_reset_sequencer: CFG_W must be 16");
    end

    // Synchronised inputs
    logic             pin_sync;      // Reset pin after filtering
    logic [CFG_W-1:0] port_sync;     // Startup port after filtering

    // State and counters
    seq_state_e       state_ff;      // Sequencer state
    seq_state_e       nxt_state;     // Next sequencer state
    logic [CNT_W-1:0] cnt_ff;        // Shared cycle counter
    logic [CNT_W-1:0] nxt_cnt;       // Next counter value

    // Output registers
    logic             pin_oe_ff;     // Drives pin low when set
    logic             int_rst_ff;    // Reset condition
    logic             rst_out_n_ff;  // Reset output level
    logic             emu_ff;        // Emulation bit
    logic             cfg_bit_a_ff;      // Cfg_bit_a bit
    logic [2:0]       clk_cfg_ff;    // Clock configuration
    logic             ale_ff;        // Strobe level
    logic             fetch_ff;      // Fetch start pulse
    logic             cancel_ff;     // Hold cancel pulse
    logic             io_dis_ff;     // General I/O kept off

    // Reset pin through three stages before any use
    // Idles low, so power-up reset waits for a real high sample
    reset_in_sync #(
        .WIDTH    (1),
        .IDLE_VAL ({15'h0000, RST_PIN_LEVEL})
    ) u_pin_sync (
        .i_clock    (i_clock),
        .i_resetn   (i_resetn),
        .i_clock_en (i_clock_en),
        .i_async    (i_reset_in_n),
        .o_sync     (pin_sync)
    );

    // Startup port lines idle high, as the pull-ups leave them
    reset_in_sync #(
        .WIDTH    (CFG_W),
        .IDLE_VAL (16'hffff)
    ) u_port_sync (
        .i_clock    (i_clock),
        .i_resetn   (i_resetn),
        .i_clock_en (i_clock_en),
        .i_async    (i_startup_config_port),
        .o_sync     (port_sync)
    );

    // Returns true when the counter has reached a given count
    function automatic logic cnt_at(input logic [CNT_W-1:0] c, input int n);
        cnt_at = (c == CNT_W'(n));
    endfunction

    // Next-state logic
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff + CNT_W'(1);
        case (state_ff)
            // Watch for the pin going low
            ST_RUN: begin
                nxt_cnt = '0;
                if (!pin_sync) begin
                    nxt_state = ST_DETECT;
                end
            end
            // Let the running access finish; start inside the window
            ST_DETECT: begin
                if (cnt_at(cnt_ff, START_MAX_CYC - 1) ||
                    (cnt_ff >= CNT_W'(START_MIN_CYC - 1) && !i_access_busy)) begin
                    nxt_state = ST_SEQ;
                    nxt_cnt   = '0;
                end
            end
            // Fixed-length internal sequence
            ST_SEQ: begin
                if (cnt_at(cnt_ff, SEQ_CYCLES - 1)) begin
                    nxt_state = ST_WAIT_HIGH;
                    nxt_cnt   = '0;
                end
            end
            // Extend reset until the pin reads high
            ST_WAIT_HIGH: begin
                nxt_cnt = '0;
                if (pin_sync) begin
                    nxt_state = ST_ALE_WAIT;
                end
            end
            // Count out the strobe delay
            ST_ALE_WAIT: begin
                if (cnt_at(cnt_ff, ALE_CYCLES - 1)) begin
                    nxt_state = ST_RUN;
                    nxt_cnt   = '0;
                end
            end
            // Unused codes fall back to waiting for pin high
            default: begin
                nxt_state = ST_WAIT_HIGH;
                nxt_cnt   = '0;
            end
        endcase
    end

    // State register; power-up reset lands in the wait state at once
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff <= ST_WAIT_HIGH;
            cnt_ff   <= '0;
        end else if (i_clock_en) begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // Reset condition and pin drive
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            int_rst_ff <= 1'b1;
            pin_oe_ff  <= 1'b0;
        end else if (i_clock_en) begin
            int_rst_ff <= (nxt_state == ST_SEQ) || (nxt_state == ST_WAIT_HIGH);
            pin_oe_ff  <= (nxt_state == ST_SEQ);
        end
    end

    // Hold cancel pulse as the warm reset is detected
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cancel_ff <= 1'b0;
        end else if (i_clock_en) begin
            cancel_ff <= (state_ff == ST_RUN) && (nxt_state == ST_DETECT);
        end
    end

    // Startup bits follow the port while reset is active
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            emu_ff     <= 1'b1;
            cfg_bit_a_ff   <= 1'b1;
            clk_cfg_ff <= RST_CLK_CFG;
        end else if (i_clock_en && int_rst_ff) begin
            emu_ff     <= port_sync[CFG_EMU_POS];
            cfg_bit_a_ff   <= port_sync[CFG_A_POS];
            clk_cfg_ff <= port_sync[CFG_CLK_HI:CFG_CLK_LO];
        end
    end

    // First strobe and fetch start, one cycle each
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ale_ff   <= 1'b0;
            fetch_ff <= 1'b0;
        end else if (i_clock_en) begin
            ale_ff   <= (state_ff == ST_ALE_WAIT) && cnt_at(cnt_ff, ALE_CYCLES - 1);
            fetch_ff <= (state_ff == ST_ALE_WAIT) && cnt_at(cnt_ff, ALE_CYCLES - 1);
        end
    end

    // Reset output: low through reset, high after end-of-init
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_out_n_ff <= 1'b0;
            io_dis_ff    <= 1'b1;
        end else if (i_clock_en) begin
            if (int_rst_ff || state_ff == ST_DETECT) begin
                rst_out_n_ff <= 1'b0;
                io_dis_ff    <= 1'b1;
            end else if (i_end_of_init_instr && state_ff == ST_RUN) begin
                rst_out_n_ff <= 1'b1;
                io_dis_ff    <= 1'b0;
            end
        end
    end

    // Output wiring, all from flip-flops except the constant pin drive value and fetch address
    assign o_reset_in_n_out    = 1'b0;           // Only ever pulls low
    assign o_reset_in_n_oe     = pin_oe_ff;
    assign o_port_pullup_en    = int_rst_ff;
    assign o_cancel_holds      = cancel_ff;
    assign o_internal_reset    = int_rst_ff;
    assign o_reset_out_n       = rst_out_n_ff;
    assign o_emulation_cfg_bit = emu_ff;
    assign o_cfg_bit_a         = cfg_bit_a_ff;
    assign o_clock_cfg         = clk_cfg_ff;
    assign o_ale               = ale_ff;
    assign o_fetch_start       = fetch_ff;
    assign o_fetch_addr        = START_ADDR;
    assign o_io_disable        = io_dis_ff;

endmodule

// file: hardware_reset_sequencer_properties.sv
// Timing checks on the reset sequencer ports
module reset_seq_checker
    import reset_seq_pkg::*;
#(
    parameter int CFG_W = 16  // Startup port width
) (
    input wire logic              i_clock,             // CPU clock
    input wire logic              i_resetn,            // Power-up reset
    input wire logic              i_reset_in_n,        // Pin level
    input wire logic              i_end_of_init_instr, // End-of-init pulse
    input wire logic              o_reset_in_n_out,    // Pin drive value
    input wire logic              o_reset_in_n_oe,     // Pin drive enable
    input wire logic              o_port_pullup_en,    // Pull-ups on
    input wire logic              o_cancel_holds,      // Hold cancel pulse
    input wire logic              o_internal_reset,    // Reset condition
    input wire logic              o_reset_out_n,       // Reset output
    input wire logic              o_emulation_cfg_bit, // Captured bit 0
    input wire logic              o_cfg_bit_a,         // Captured bit 1
    input wire logic [2:0]        o_clock_cfg,         // Captured clock bits
    input wire logic              o_ale,               // First strobe
    input wire logic              o_fetch_start,       // Fetch pulse
    input wire logic [ADDR_W-1:0] o_fetch_addr,        // Fetch address
    input wire logic              o_io_disable         // I/O kept off
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    logic [9:0] oe_cnt_ff;  // Cycles the pin has been driven low

    // Counts the length of the driven-low phase
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) oe_cnt_ff <= 10'h0;
        else oe_cnt_ff <= o_reset_in_n_oe ? oe_cnt_ff + 10'h1 : 10'h0;
    end

    sequence strobe_s;  // Four quiet cycles, then one strobe
        !o_ale [*4] ##1 o_ale ##1 !o_ale;
    endsequence
    sequence start_s;   // Pulse ends, sequence starts within the window
        ##1 !o_cancel_holds ##[1:7] (o_reset_in_n_oe && o_internal_reset);
    endsequence

    ale_timing_a: assert property ($fell(o_internal_reset) |-> strobe_s)
        else $error("first strobe off time");
    seq_start_a: assert property (o_cancel_holds |-> start_s)
        else $error("sequence start outside window");
    oe_length_a: assert property ($fell(o_reset_in_n_oe) |-> oe_cnt_ff == 10'h200)
        else $error("pin drive length wrong");
    oe_bound_a: assert property (o_reset_in_n_oe |-> oe_cnt_ff < 10'h200)
        else $error("pin driven too long");
    pin_low_a: assert property (o_reset_in_n_oe |-> !o_reset_in_n_out && o_internal_reset)
        else $error("pin not driven low in sequence");
    reset_end_a: assert property ($fell(o_internal_reset) |-> $past(i_reset_in_n, 2) && !o_reset_in_n_oe)
        else $error("reset ended with pin low");
    cfg_frozen_a: assert property (!o_internal_reset && !$past(o_internal_reset)
        |-> $stable({o_clock_cfg, o_cfg_bit_a, o_emulation_cfg_bit}))
        else $error("config changed outside reset");
    pullup_on_a: assert property (o_port_pullup_en == o_internal_reset)
        else $error("pull-ups not tied to reset");
    out_release_a: assert property ($rose(o_reset_out_n) |-> $past(i_end_of_init_instr))
        else $error("reset output released early");
    out_held_a: assert property (o_internal_reset && $past(o_internal_reset) |-> !o_reset_out_n)
        else $error("reset output high in reset");
    io_off_a: assert property (!o_reset_out_n |-> o_io_disable)
        else $error("io enabled in reset");
    fetch_a: assert property (o_ale == o_fetch_start && o_fetch_addr == START_ADDR)
        else $error("fetch start wrong");
endmodule

// file: hardware_reset_sequencer_tb.sv
// Bench: power-up, warm resets with random timing and config, mid-run power reset
module hardware_reset_sequencer_tb
    import reset_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, resetn = 0, busy = 0, eoi = 0, go = 0;  // Driven inputs
    logic [11:0] low_cyc = 12'h0;   // Source low time
    logic [15:0] mask = 16'h0;      // Pulldown lines
    logic pin_n, oe, pout, pu, src_busy;  // Pin and pull-up nets
    logic [15:0] port;              // Startup port lines
    logic cancel, irst, rout_n, emulation_cfg_bit, cfa, ale, fst, iod;  // Outputs
    logic [2:0] ccfg;               // Clock config seen
    logic [ADDR_W-1:0] faddr;       // Fetch address seen
    int seed = 49, fail_count = 0, num_checks = 0, n;  // Seed, counters

    always #20 clock = ~clock;  // 25 MHz

    hardware_reset_sequencer u_dut (.i_clock(clock), .i_resetn(resetn), .i_clock_en(1'b1),
        .i_reset_in_n(pin_n), .o_reset_in_n_out(pout), .o_reset_in_n_oe(oe),
        .i_startup_config_port(port), .o_port_pullup_en(pu), .i_access_busy(busy),
        .i_end_of_init_instr(eoi), .o_cancel_holds(cancel), .o_internal_reset(irst),
        .o_reset_out_n(rout_n), .o_emulation_cfg_bit(emulation_cfg_bit), .o_cfg_bit_a(cfa),
        .o_clock_cfg(ccfg), .o_ale(ale), .o_fetch_start(fst), .o_fetch_addr(faddr),
        .o_io_disable(iod));
    reset_source_model u_src (.i_clock(clock), .i_go(go), .i_low_cyc(low_cyc), .i_pin_oe(oe),
        .i_pin_out(pout), .i_pullup_en(pu), .i_pd_mask(mask), .o_pin_n(pin_n),
        .o_port(port), .o_busy(src_busy));

    // Expected captured bits from the pulldown pattern
    function automatic logic [4:0] exp_cfg(input logic [15:0] m);
        return {~m[15:13], ~m[1], ~m[0]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One cycle, inputs and sampling just after the edge; bounded
    task automatic step(inout int k, input int lim);
        @(posedge clock);
        #2;
        k++;
        if (k > lim) begin
            check("wait bound", 0, 1);
            stop_test();
        end
    endtask
    // Reset end, then the strobe and fetch start
    task automatic end_and_strobe(input logic [4:0] cfg);
        n = 0;
        while (irst !== 1'b0) step(n, 3000);
        check("pin free at end", src_busy, 0);
        check("config", {ccfg, cfa, emulation_cfg_bit}, cfg);
        check("io off", iod, 1);
        n = 0;
        while (ale !== 1'b1) step(n, 10);
        check("strobe delay", n, ALE_CYCLES);
        check("fetch", {fst, faddr}, {1'b1, START_ADDR});
        check("out held", rout_n, 0);
        eoi = 1;
        step(n, 99);
        eoi = 0;
        check("out released", rout_n, 1);
    endtask

    initial begin
        repeat (8) @(posedge clock);
        #2 resetn = 1;
        end_and_strobe(5'h1f);
        $display("test power-up done");
        for (int i = 0; i < 5; i++) begin
            mask = 16'($random(seed));
            low_cyc = (i == 4) ? 12'h320 : 12'($unsigned($random(seed)) % 200);
            busy = (i == 3) ? 1'b1 : (i == 0) ? 1'b0 : 1'($random(seed));
            go = 1;
            step(n, 99);
            go = 0;
            n = 0;
            while (cancel !== 1'b1) step(n, 12);
            n = 0;
            while (oe !== 1'b1) step(n, 10);
            check("start delay", n, busy ? START_MAX_CYC : START_MIN_CYC);
            busy = 0;
            n = 0;
            while (oe === 1'b1) step(n, 600);
            check("drive length", n, SEQ_CYCLES);
            check("out low in reset", rout_n, 0);
            end_and_strobe(exp_cfg(mask));
            repeat (6) step(n, 99);
            check("config kept", {ccfg, cfa, emulation_cfg_bit}, exp_cfg(mask));
            $display("test warm %0d done", i);
        end
        resetn = 0;
        #1 check("async reset", {irst, oe, ccfg, cfa, emulation_cfg_bit}, 7'h5f);
        repeat (2) @(posedge clock);
        #2 resetn = 1;
        end_and_strobe(exp_cfg(mask));
        $display("test mid-run reset done");
        stop_test();
    end
endmodule

bind hardware_reset_sequencer reset_seq_checker #(.CFG_W(CFG_W)) u_chk (.i_clock(i_clock),
    .i_resetn(i_resetn), .i_reset_in_n(i_reset_in_n), .i_end_of_init_instr(i_end_of_init_instr),
    .o_reset_in_n_out(o_reset_in_n_out), .o_reset_in_n_oe(o_reset_in_n_oe),
    .o_port_pullup_en(o_port_pullup_en), .o_cancel_holds(o_cancel_holds),
    .o_internal_reset(o_internal_reset), .o_reset_out_n(o_reset_out_n),
    .o_emulation_cfg_bit(o_emulation_cfg_bit), .o_cfg_bit_a(o_cfg_bit_a),
    .o_clock_cfg(o_clock_cfg), .o_ale(o_ale), .o_fetch_start(o_fetch_start),
    .o_fetch_addr(o_fetch_addr), .o_io_disable(o_io_disable));

// file: reset_in_sync.sv
// Three-stage synchroniser; a change is accepted when stages two and three agree
module reset_in_sync
    import reset_seq_pkg::*;
#(
    parameter int          WIDTH    = 1,    // Number of lines
    parameter logic [15:0] IDLE_VAL = '1    // Value after reset
) (
    input  wire logic             i_clock,    // CPU clock
    input  wire logic             i_resetn,   // Async reset, active low
    input  wire logic             i_clock_en, // Freezes state when low
    input  wire logic [WIDTH-1:0] i_async,    // Lines from outside
    output logic      [WIDTH-1:0] o_sync      // Filtered result
);

    // Refuse widths the filter cannot serve
    if (WIDTH < 1 || WIDTH > 16) begin : g_width_check
        $error("reset_in_sync: WIDTH out of range");
    end

    logic [WIDTH-1:0] stage1_ff;  // Metastability catcher
    logic [WIDTH-1:0] stage2_ff;  // Second stage
    logic [WIDTH-1:0] stage3_ff;  // Third stage
    logic [WIDTH-1:0] out_ff;     // Accepted value

    // Shift chain; stage one feeds stage two only
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            stage1_ff <= IDLE_VAL[WIDTH-1:0];
            stage2_ff <= IDLE_VAL[WIDTH-1:0];
            stage3_ff <= IDLE_VAL[WIDTH-1:0];
        end else if (i_clock_en) begin
            stage1_ff <= i_async;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    // Per line, accept the value once two stages agree
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            out_ff <= IDLE_VAL[WIDTH-1:0];
        end else if (i_clock_en) begin
            out_ff <= (stage2_ff & stage3_ff) | (out_ff & (stage2_ff ^ stage3_ff));
        end
    end

    assign o_sync = out_ff;

endmodule

// file: reset_seq_pkg.sv
// Functional notes
// - First address strobe rises 8 half-periods after reset end
// - Emulation, cfg_bit_a, clock bits loaded during internal reset
// - Power-up reset acts at once, no clock
// - Fetch starts at address zero after reset
// - Reset output held until end-of-init instruction
// - Warm reset cancels holds, finishes running access
// - Reset pin driven low during internal sequence
// - Reset ends only when pin sampled high
// - Reset logic keeps general I/O drivers off until end-of-init instruction
// - Startup port lines pulled up during reset
// - Sequence starts 4 to 16 half-periods after detect
// - Internal sequence lasts exactly 1024 half-periods
package reset_seq_pkg;

    // Clock and half-period timing
    localparam int CLK_PERIOD_NS  = 40;                  // CPU clock period
    localparam int HALF_PERIOD_NS = CLK_PERIOD_NS / 2;   // One half_clock_period
    localparam int HP_PER_CYCLE   = 2;                   // Half-periods per clock

    // Figures in half-periods, async low time in ns
    localparam int ALE_DELAY_HP   = 8;                   // Reset end to first strobe
    localparam int SEQ_LEN_HP     = 1024;                // Internal sequence length
    localparam int START_MIN_HP   = 4;                   // Detect to sequence, least
    localparam int START_MAX_HP   = 16;                  // Detect to sequence, most
    localparam int ASYNC_LOW_NS   = 1500;                // Least async low time

    // Derived cycle counts (least rounds up, longest rounds down)
    localparam int ALE_CYCLES     = ALE_DELAY_HP / HP_PER_CYCLE;
    localparam int SEQ_CYCLES     = SEQ_LEN_HP / HP_PER_CYCLE;
    localparam int START_MIN_CYC  = (START_MIN_HP + HP_PER_CYCLE - 1) / HP_PER_CYCLE;
    localparam int START_MAX_CYC  = START_MAX_HP / HP_PER_CYCLE;
    localparam int ASYNC_LOW_CYC  = (ASYNC_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Counter width and fetch address
    localparam int CNT_W          = 10;                  // Holds SEQ_CYCLES
    localparam int ADDR_W         = 24;                  // Fetch address width
    localparam logic [23:0] START_ADDR = 24'h00_0000;   // First fetch address

    // Startup configuration field positions
    localparam int CFG_EMU_POS    = 0;                   // emulation_cfg_bit
    localparam int CFG_A_POS      = 1;                   // cfg_bit_a
    localparam int CFG_CLK_LO     = 13;                  // Clock config low bit
    localparam int CFG_CLK_HI     = 15;                  // Clock config high bit

    // Reset values
    localparam logic       RST_PIN_LEVEL = 1'b0;         // Pin reads low until sampled
    localparam logic [2:0] RST_CLK_CFG   = 3'h7;         // Clock config after reset

    // Sequencer states
    typedef enum logic [2:0] {
        ST_RUN,        // Normal operation
        ST_DETECT,     // Warm reset seen, waiting to start
        ST_SEQ,        // Internal sequence, pin driven low
        ST_WAIT_HIGH,  // Waiting for pin high
        ST_ALE_WAIT    // Reset ended, timing first strobe
    } seq_state_e;

endpackage

// file: reset_source_model.sv
// External reset source with pull-up on the pin and the startup port lines
module reset_source_model
    import reset_seq_pkg::*;
(
    input  wire logic        i_clock,     // CPU clock
    input  wire logic        i_go,        // Start a low request
    input  wire logic [11:0] i_low_cyc,   // Requested low cycles
    input  wire logic        i_pin_oe,    // Device drives pin
    input  wire logic        i_pin_out,   // Device drive value
    input  wire logic        i_pullup_en, // Device pull-ups on
    input  wire logic [15:0] i_pd_mask,   // Lines with external pulldown
    output logic             o_pin_n,     // Resolved pin level
    output logic [15:0]      o_port,      // Startup port lines
    output logic             o_busy       // Source still pulling low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] cnt_ff   = 12'h0;    // Remaining low cycles
    logic [15:0] float_ff = 16'h5a5a; // Changing level of floating lines

    // Never shorter than the minimum low time
    always_ff @(posedge i_clock) begin
        if (i_go) cnt_ff <= (i_low_cyc < ASYNC_LOW_CYC) ? 12'(ASYNC_LOW_CYC) : i_low_cyc;
        else if (cnt_ff != 12'h0) cnt_ff <= cnt_ff - 12'h1;
        float_ff <= ~float_ff;
    end
    assign o_busy  = (cnt_ff != 12'h0);
    // Wired pin: either party pulls low, resistor pulls high
    assign o_pin_n = !((i_pin_oe && !i_pin_out) || o_busy);
    // Open lines read high while pulled up, and follow the toggling float_ff level otherwise
    assign o_port  = ~i_pd_mask & (i_pullup_en ? 16'hffff : float_ff);
endmodule
